// file: hw/dsc_pkg.sv
// Shared constants of the serial DAC control link: frame layout, commands,
// control register fields, reset values, link timing and host register map.
// Assumes a single 20 MHz system clock on both ends.
package dsc_pkg;
    localparam int          CLK_NS        = 50;
    localparam int          FRAME_BITS    = 24;
    localparam int          ADDR_LSB      = 16;
    localparam int          FIXED_BIT     = 20;
    localparam logic [4:0]  LAST_BIT_IDX  = 5'h17;

    localparam logic [3:0]  CMD_NOP        = 4'h0;
    localparam logic [3:0]  CMD_WR_INPUT   = 4'h1;
    localparam logic [3:0]  CMD_UPD_DAC    = 4'h2;
    localparam logic [3:0]  CMD_WR_UPD     = 4'h3;
    localparam logic [3:0]  CMD_WR_CTRL    = 4'h4;
    localparam logic [3:0]  CMD_RD_INPUT   = 4'hA;
    localparam logic [3:0]  CMD_RD_DAC     = 4'hB;
    localparam logic [3:0]  CMD_RD_CTRL    = 4'hC;
    localparam logic [3:0]  CMD_FULL_RESET = 4'hF;

    localparam int          CTRL_SDO_OFF_BIT = 5;
    localparam int          CTRL_THERM_BIT   = 8;
    localparam int          CTRL_CLR_LSB     = 9;
    localparam int          CTRL_BROWN_BIT   = 11;
    localparam int          CTRL_SHORT_BIT   = 12;
    localparam logic [15:0] CTRL_WR_MASK     = 16'h07FF;
    localparam logic [15:0] CTRL_RST         = 16'h0000;
    localparam logic [15:0] CODE_RST         = 16'h0000;

    localparam logic [15:0] CLR_ZERO = 16'h0000;
    localparam logic [15:0] CLR_MID  = 16'h8000;
    localparam logic [15:0] CLR_FULL = 16'hFFFF;

    localparam int          SCLK_HALF_NS  = 400;
    localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [7:0]  ADDR_TX   = 8'h00;
    localparam logic [7:0]  ADDR_RX   = 8'h04;
    localparam logic [7:0]  ADDR_PINS = 8'h08;
    localparam logic [7:0]  ADDR_STAT = 8'h0C;
    localparam logic [2:0]  PINS_RST  = 3'h7;

    function automatic logic [15:0] clear_code(input logic [1:0] sel);
        unique case (sel)
            2'h0:    clear_code = CLR_ZERO;
            2'h1:    clear_code = CLR_MID;
            default: clear_code = CLR_FULL;
        endcase
    endfunction
endpackage

// file: hw/dsc_link_if.sv
// Four-wire serial link plus load, clear, reset and alert pins.
// The data-out wire idles high when the device does not drive it.
`timescale 1ns/1ps
interface dsc_link_if;
    logic frame_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;
    logic load_n;
    logic clear_n;
    logic reset_n;
    logic alert_n;

    assign sdo_line = sdo_oe ? sdo : 1'b1;

    modport dev  (input frame_n, sclk, sdi, load_n, clear_n, reset_n,
                  output sdo, sdo_oe, alert_n);
    modport host (output frame_n, sclk, sdi, load_n, clear_n, reset_n,
                  input sdo_line, alert_n);
endinterface

// file: hw/dsc_sync.sv
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a level; RST_VAL is the idle level of each bit.
`timescale 1ns/1ps
module dsc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dsc_sync_st_t;

    dsc_sync_st_t st_q;
    dsc_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{s1: RST_VAL, s2: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule

// file: hw/dsc_dac_end.sv
// Device end: serial control logic of a single-channel voltage-output DAC.
// Assumes link pins and fault levels are asynchronous; all are synchronised.
`timescale 1ns/1ps
module dsc_dac_end
    import dsc_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    dsc_link_if.dev          link,
    input  wire logic        short_circuit_in,
    input  wire logic        brownout_in,
    input  wire logic        overtemp_in,
    output logic      [15:0] out_code,
    output logic      [2:0]  out_range,
    output logic             out_clamp,
    output logic             buffer_on,
    output logic             digital_supply_on
);
    if (DATA_W != 16 && DATA_W != 12) begin : g_bad_width
        $error("dsc_dac_end: DATA_W must be 12 or 16");
    end

    localparam logic [15:0] DMASK = 16'(16'hFFFF << (16 - DATA_W));

    typedef struct packed {
        logic [3:0]  prev;
        logic        in_frame;
        logic [23:0] sr;
        logic [4:0]  mod;
        logic        got;
        logic [15:0] inreg;
        logic [15:0] dacreg;
        logic [15:0] ctrl;
        logic [15:0] outc;
        logic        sdo;
        logic        oe;
        logic        alert_n;
        logic        configured;
        logic        clamp;
        logic        buf_on;
        logic        supply_on;
    } dsc_dev_st_t;

    localparam dsc_dev_st_t DEV_RST = '{
        prev: 4'hF, in_frame: 1'b0, sr: 24'h000000, mod: 5'h00, got: 1'b0,
        inreg: CODE_RST, dacreg: CODE_RST, ctrl: CTRL_RST, outc: CODE_RST,
        sdo: 1'b0, oe: 1'b0, alert_n: 1'b0, configured: 1'b0,
        clamp: 1'b1, buf_on: 1'b0, supply_on: 1'b1};

    logic [8:0]  s;
    dsc_dev_st_t q;
    dsc_dev_st_t n;

    dsc_sync #(
        .W       (9),
        .RST_VAL (9'h1F8)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link.frame_n, link.sclk, link.load_n, link.clear_n, link.sdi,
                   link.reset_n, short_circuit_in, brownout_in, overtemp_in}),
        .q       (s)
    );

    wire s_frame = s[8];
    wire s_sclk  = s[7];
    wire s_load  = s[6];
    wire s_clr   = s[5];
    wire s_sdi   = s[4];
    wire s_rst   = s[3];
    wire s_short = s[2];
    wire s_brown = s[1];
    wire s_ot    = s[0];

    // Readback word carries the command back with the register value
    function automatic logic [23:0] rb_word(input logic [3:0] cmd, input logic [15:0] v);
        rb_word = {4'h0, cmd, v & DMASK};
    endfunction

    always_comb begin
        logic [15:0] d;
        logic [3:0]  cmd;
        logic        frame_fall;
        logic        frame_rise;
        logic        sclk_fall;
        logic        sclk_rise;
        d          = q.sr[15:0] & DMASK;
        cmd        = q.sr[ADDR_LSB +: 4];
        frame_fall = q.prev[3] & ~s_frame;
        frame_rise = ~q.prev[3] & s_frame;
        sclk_fall  = q.prev[2] & ~s_sclk;
        sclk_rise  = ~q.prev[2] & s_sclk;
        n          = q;
        n.prev     = {s_frame, s_sclk, s_load, s_clr};
        // A powered-down part ignores the link until a reset
        if (q.supply_on) begin
            if (frame_fall) begin
                n.in_frame = 1'b1;
                n.mod      = 5'h00;
                n.got      = 1'b0;
                n.sdo      = q.sr[23];
            end
            if (q.in_frame && sclk_fall) begin
                n.sr  = {q.sr[22:0], s_sdi};
                n.mod = (q.mod == LAST_BIT_IDX) ? 5'h00 : q.mod + 5'h01;
                n.got = q.got | (q.mod == LAST_BIT_IDX);
            end
            if (q.in_frame && sclk_rise) begin
                n.sdo = q.sr[23];
            end
            if (q.in_frame && frame_rise) begin
                n.in_frame = 1'b0;
                // Only whole multiples of 24 edges count, so chains still work
                if (q.got && q.mod == 5'h00 && !q.sr[FIXED_BIT]) begin
                    unique case (cmd)
                        CMD_WR_INPUT: begin
                            n.inreg = d;
                            if (!s_load) begin
                                n.dacreg = d;
                                n.outc   = d;
                            end
                        end
                        CMD_WR_UPD: begin
                            n.inreg  = d;
                            n.dacreg = d;
                            n.outc   = d;
                        end
                        CMD_UPD_DAC: begin
                            n.dacreg = q.inreg;
                            n.outc   = q.inreg;
                        end
                        CMD_WR_CTRL: begin
                            n.ctrl       = (q.ctrl & ~CTRL_WR_MASK) | (d & CTRL_WR_MASK);
                            n.configured = 1'b1;
                            n.clamp      = 1'b0;
                            n.buf_on     = 1'b1;
                        end
                        CMD_RD_INPUT: n.sr = rb_word(cmd, q.inreg);
                        CMD_RD_DAC:   n.sr = rb_word(cmd, q.dacreg);
                        CMD_RD_CTRL: begin
                            n.sr                = rb_word(cmd, q.ctrl);
                            // Reading the cause clears the fault flags
                            n.ctrl[CTRL_SHORT_BIT] = 1'b0;
                            n.ctrl[CTRL_BROWN_BIT] = 1'b0;
                        end
                        CMD_FULL_RESET: begin
                            n      = DEV_RST;
                            n.prev = {s_frame, s_sclk, s_load, s_clr};
                        end
                        default: ;
                    endcase
                end
            end
            if (q.prev[1] && !s_load && !q.in_frame && s_frame) begin
                n.dacreg = q.inreg;
                n.outc   = q.inreg;
            end
            // Clear wins over a load in the same cycle
            if (q.prev[0] && !s_clr) begin
                n.outc = clear_code(q.ctrl[CTRL_CLR_LSB +: 2]);
            end
        end
        // Fault flags: a live fault wins over the clear on read
        if (s_short) begin
            n.ctrl[CTRL_SHORT_BIT] = 1'b1;
        end
        if (s_brown) begin
            n.ctrl[CTRL_BROWN_BIT] = 1'b1;
        end
        if (s_ot && q.ctrl[CTRL_THERM_BIT]) begin
            n.supply_on = 1'b0;
        end
        if (!s_rst) begin
            n      = DEV_RST;
            n.prev = {s_frame, s_sclk, s_load, s_clr};
        end
        n.alert_n = n.configured & ~n.ctrl[CTRL_SHORT_BIT] & ~n.ctrl[CTRL_BROWN_BIT]
                  & ~s_ot;
        n.oe      = n.in_frame & ~n.ctrl[CTRL_SDO_OFF_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= DEV_RST;
        end else begin
            q <= n;
        end
    end

    assign link.sdo          = q.sdo;
    assign link.sdo_oe       = q.oe;
    assign link.alert_n      = q.alert_n;
    assign out_code          = q.outc;
    assign out_range         = q.ctrl[2:0];
    assign out_clamp         = q.clamp;
    assign buffer_on         = q.buf_on;
    assign digital_supply_on = q.supply_on;
endmodule

// file: hw/dsc_host_end.sv
// Host end: APB-programmed serial master that sends one 24-bit frame per
// write and captures the data-out word. Assumes APB on the same clock.
`timescale 1ns/1ps
module dsc_host_end
    import dsc_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    dsc_link_if.host         link
);
    // Readback passes two synchronisers and the device logic, about 6 cycles
    if (HALF_CYC < 6 || HALF_CYC > 256) begin : g_bad_half
        $error("dsc_host_end: HALF_CYC must lie in 6..256");
    end

    typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_END, HS_GAP} dsc_hst_state_t;

    typedef struct packed {
        dsc_hst_state_t st;
        logic [7:0]     div;
        logic [4:0]     cnt;
        logic [23:0]    tx;
        logic [23:0]    rx;
        logic [23:0]    rxd;
        logic           frame_n;
        logic           sclk;
        logic           sdi;
        logic [2:0]     pins;
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
    } dsc_hst_st_t;

    localparam dsc_hst_st_t HST_RST = '{
        st: HS_IDLE, div: 8'h00, cnt: 5'h00, tx: 24'h000000, rx: 24'h000000,
        rxd: 24'h000000, frame_n: 1'b1, sclk: 1'b1, sdi: 1'b0, pins: PINS_RST,
        pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};

    logic [1:0]  s;
    dsc_hst_st_t q;
    dsc_hst_st_t n;

    dsc_sync #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link.sdo_line, link.alert_n}),
        .q       (s)
    );

    always_comb begin
        logic tick;
        logic busy;
        tick      = (q.div == 8'(HALF_CYC - 1));
        busy      = (q.st != HS_IDLE);
        n         = q;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.div     = (busy && !tick) ? q.div + 8'h01 : 8'h00;
        // Answer in the first access cycle; read data fixed at setup
        if (psel && !penable) begin
            n.pready = 1'b1;
            n.prdata = 32'h00000000;
            unique case (paddr)
                ADDR_TX:   ;
                ADDR_RX:   n.prdata = {8'h00, q.rxd};
                ADDR_PINS: n.prdata = {29'h0, q.pins};
                ADDR_STAT: n.prdata = {30'h0, s[0], busy};
                default:   n.pslverr = 1'b1;
            endcase
        end
        unique case (q.st)
            HS_IDLE: ;
            HS_SHIFT: if (tick) begin
                if (q.sclk) begin
                    n.sclk = 1'b0;
                    n.rx   = {q.rx[22:0], s[1]};
                    n.cnt  = q.cnt + 5'h01;
                end else begin
                    n.sclk = 1'b1;
                    n.tx   = {q.tx[22:0], 1'b0};
                    n.sdi  = q.tx[22];
                    if (q.cnt == LAST_BIT_IDX + 5'h01) begin
                        n.st = HS_END;
                    end
                end
            end
            HS_END: if (tick) begin
                n.frame_n = 1'b1;
                n.st      = HS_GAP;
            end
            HS_GAP: if (tick) begin
                n.rxd = q.rx;
                n.st  = HS_IDLE;
            end
        endcase
        if (psel && penable && q.pready && pwrite) begin
            // A frame write while busy is dropped; software polls busy first
            if (paddr == ADDR_TX && !busy) begin
                n.tx      = pwdata[23:0];
                n.sdi     = pwdata[23];
                n.frame_n = 1'b0;
                n.cnt     = 5'h00;
                n.div     = 8'h00;
                n.st      = HS_SHIFT;
            end
            if (paddr == ADDR_PINS) begin
                n.pins = pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= HST_RST;
        end else begin
            q <= n;
        end
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign link.frame_n = q.frame_n;
    assign link.sclk    = q.sclk;
    assign link.sdi     = q.sdi;
    assign link.load_n  = q.pins[0];
    assign link.clear_n = q.pins[1];
    assign link.reset_n = q.pins[2];
endmodule

// file: verif/dsc_link_props.sv
// Checker for the serial link between the host end and the device end.
// Assumes every frame carries 24 clock falls and the data-out pin stays enabled.
`timescale 1ns/1ps
module dsc_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic reset_n,
    input wire logic alert_n
);
    logic [5:0] fall_cnt_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counter clears while idle so a partial frame never leaks into the next
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fall_cnt_q <= 6'h00;
        end else if (frame_n) begin
            fall_cnt_q <= 6'h00;
        end else if ($fell(sclk)) begin
            fall_cnt_q <= fall_cnt_q + 6'h01;
        end
    end

    frame_count_a: assert property ($rose(frame_n) |-> fall_cnt_q == 6'h18)
        else $error("frame closed without 24 clock falls");
    sclk_idle_a: assert property (frame_n |-> sclk)
        else $error("serial clock active outside a frame");
    sdi_hold_a: assert property ($fell(sclk) |-> $stable(sdi))
        else $error("data in moved at the sampling edge");
    sdo_hold_a: assert property ($fell(sclk) |-> sdo == $past(sdo, 2))
        else $error("data out not settled before falling edge");
    sdo_release_a: assert property (frame_n [*6] |-> !sdo_oe)
        else $error("data out driven while frame select high");
    sdo_enable_a: assert property (!frame_n [*6] |-> sdo_oe)
        else $error("data out not driven inside a frame");
    alert_rise_a: assert property ($rose(alert_n) |-> frame_n && reset_n)
        else $error("alert released at an unexpected moment");
    alert_reset_a: assert property (!reset_n [*5] |-> !alert_n)
        else $error("alert high while reset pin held");
endmodule

// file: verif/tb_dac_serial_control_logic.sv
// Bench: APB drives the host end, which talks to the device end; a second
// device is bit-banged by the bench to send frames of 23, 24, 25 and 48 clock falls.
`timescale 1ns/1ps
module tb_dac_serial_control_logic;
    import dsc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        short_in, brown_in, ot_in, supply, clamp, buf_on;
    logic [15:0] code, code2, v, w, ctl;
    logic [2:0]  range;
    int          error_cnt, total_checks, seed;
    dsc_link_if  link ();
    dsc_link_if  link2 ();

    dsc_host_end dsc_host_end_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    dsc_dac_end dsc_dac_end_i (.pclk(pclk), .presetn(presetn), .link(link),
        .short_circuit_in(short_in), .brownout_in(brown_in), .overtemp_in(ot_in), .out_code(code),
        .out_range(range), .out_clamp(clamp), .buffer_on(buf_on), .digital_supply_on(supply));
    dsc_dac_end bad_dsc_dac_end_i (.pclk(pclk), .presetn(presetn), .link(link2),
        .short_circuit_in(short_in), .brownout_in(brown_in), .overtemp_in(ot_in), .out_code(code2),
        .out_range(), .out_clamp(), .buffer_on(), .digital_supply_on());
    dsc_link_props dsc_link_props_i (.pclk(pclk), .presetn(presetn), .frame_n(link.frame_n),
        .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
        .reset_n(link.reset_n), .alert_n(link.alert_n));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [15:0] clr_exp(input logic [1:0] s);
        return (s == 2'h0) ? 16'h0000 : ((s == 2'h1) ? 16'h8000 : 16'hFFFF);
    endfunction

    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is sampled high; no latency is assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            wrap_up();
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send(input logic [23:0] f);
        int n;
        apb(1'b1, ADDR_TX, {8'h00, f});
        n = 0;
        do begin
            apb(1'b0, ADDR_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 200);
        if (n >= 200) begin
            error_cnt++;
            wrap_up();
        end
    endtask

    // A lone read needs a no-op frame to bring the word out
    task automatic rdreg(input logic [3:0] cmd, output logic [15:0] val);
        send({4'h0, cmd, 16'h0000});
        send(24'h000000);
        apb(1'b0, ADDR_RX, 32'h0);
        val = rd[15:0];
    endtask

    // Pins pass a two-stage synchroniser, so give them time to land
    task automatic pins(input logic [2:0] p);
        apb(1'b1, ADDR_PINS, {29'h0, p});
        repeat (6) @(posedge pclk);
    endtask

    // Bench-made 400 ns link clock with any number of falls per frame
    task automatic bang(input int n, input logic [23:0] f);
        link2.frame_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            link2.sdi <= f[23 - (i % 24)];
            repeat (4) @(posedge pclk);
            // Past 24 falls the word ripples out, one bit behind each rise
            if (i >= 24) begin
                chk(link2.sdo_line, f[23 - (i % 24)]);
            end
            link2.sclk <= 1'b0;
            repeat (4) @(posedge pclk);
            link2.sclk <= 1'b1;
        end
        repeat (4) @(posedge pclk);
        link2.frame_n <= 1'b1;
        link2.sdi <= ~link2.sdi;
        repeat (12) @(posedge pclk);
    endtask

    initial begin
        seed = 59029;
        error_cnt = 0;
        total_checks = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {short_in, brown_in, ot_in, presetn} = 4'h0;
        {link2.frame_n, link2.sclk, link2.sdi} = 3'h6;
        {link2.load_n, link2.clear_n, link2.reset_n} = 3'h7;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({code, clamp, buf_on, link.alert_n}, {16'h0000, 3'h4});
        apb(1'b0, ADDR_PINS, 32'h0);
        chk(rd, {29'h0, PINS_RST});
        apb(1'b0, 8'h10, 32'h0);
        chk({perr, rd[30:0]}, 32'h80000000);
        w = 16'h0000;
        for (int k = 0; k < 3; k++) begin
            v = 16'($random(seed));
            bang(23 + k, {4'h0, CMD_WR_UPD, v});
            if (k == 1) w = v;
            chk(code2, w);
        end
        v = 16'($random(seed));
        bang(48, {4'h0, CMD_WR_UPD, v});
        chk(code2, v);
        for (int s = 0; s < 3; s++) begin
            ctl = (16'($random(seed)) & 16'h00C7) | (16'(s) << 9);
            send({4'h0, CMD_WR_CTRL, ctl});
            chk({link.alert_n, clamp, buf_on, range}, {3'h5, ctl[2:0]});
            rdreg(CMD_RD_CTRL, w);
            chk(w, ctl);
            w = code;
            v = 16'($random(seed));
            send({3'($random(seed)), 1'b0, CMD_WR_INPUT, v});
            chk(code, w);
            rdreg(CMD_RD_INPUT, w);
            chk(w, v);
            pins(3'h6);
            chk(code, v);
            v = 16'($random(seed));
            send({4'h0, CMD_WR_INPUT, v});
            chk(code, v);
            pins(3'h7);
            rdreg(CMD_RD_DAC, w);
            chk(w, v);
            send({4'h1, CMD_WR_UPD, ~v});
            chk(code, v);
            pins(3'h5);
            chk(code, clr_exp(2'(s)));
            pins(3'h7);
            chk(code, clr_exp(2'(s)));
            send({4'h0, CMD_WR_UPD, v});
            chk(code, v);
        end
        for (int f = 0; f < 2; f++) begin
            {short_in, brown_in} <= f ? 2'b01 : 2'b10;
            repeat (6) @(posedge pclk);
            {short_in, brown_in} <= 2'b00;
            repeat (6) @(posedge pclk);
            chk(link.alert_n, 1'b0);
            rdreg(CMD_RD_CTRL, w);
            chk(w[12:11], f ? 2'b01 : 2'b10);
            rdreg(CMD_RD_CTRL, w);
            chk({w[12:11], link.alert_n}, 3'h1);
        end
        ot_in <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({supply, link.alert_n}, 2'b10);
        ot_in <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(link.alert_n, 1'b1);
        send({4'h0, CMD_FULL_RESET, 16'h0000});
        chk({code, clamp, link.alert_n}, {16'h0000, 2'b10});
        send({4'h0, CMD_WR_CTRL, 16'h0100});
        send({4'h0, CMD_WR_UPD, v});
        pins(3'h3);
        chk({code, clamp, link.alert_n}, {16'h0000, 2'b10});
        pins(3'h7);
        send({4'h0, CMD_WR_CTRL, 16'h0100});
        ot_in <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({supply, link.alert_n}, 2'b00);
        wrap_up();
    end
endmodule
